// ==== include/snd_sel_pkg.sv ====
// Constants, types and codes for the TV sound auto-select control block.
// Assumes one system clock; demodulator status arrives on that same clock.
//
// How it works
// [R1] One code write sets all demodulator parameters
// [R2] Auto detection finds, switches, reports standard code
// [R3] Code write enables carrier mute; flags show mutes
// [R4] Code write also selects matching deemphasis
// [R5] Dematrix from host register or automatic choice
// [R6] Auto dematrix follows identification, no bus access
// [R7] Silent alternation within mono-compatible groups
// [R8] Alternate only without identification; then stay
// [R9] NICAM fallback to analog mono with hysteresis
// [R10] Source codes 0,1,3,4 for four channels
// [R11] Analog channel: mono/stereo, NICAM only mono
// [R12] A/B channel: language A left, B right
// [R13] A channel: language A on both sides
// [R14] B channel: language B on both sides
// [R15] Primary mono/sum; secondary carrier 2/diff/SAP
// [R16] NICAM unusable: all four carry analog mono
// [R17] SAP standard: stereo until SAP detected
// [R18] Pilot gives mono/stereo; SAP carrier detected
// [R19] Identification gives mono, stereo or bilingual
// [R20] D/K NICAM FM deviation up to 384 kHz
// [R21] Code 21: mono left, SAP right; A mono, B SAP
// [R22] Status flags update in the same step
package snd_sel_pkg;
	// Register byte offsets
	localparam logic [7:0] OFS_STD = 8'h00;
	localparam logic [7:0] OFS_CTRL = 8'h04;
	localparam logic [7:0] OFS_DEMATRIX = 8'h08;
	localparam logic [7:0] OFS_STATUS = 8'h0c;
	localparam logic [7:0] OFS_PARAM = 8'h10;
	// Control bits and reset values
	localparam int CTRL_AUTO_BIT = 0;
	localparam int CTRL_MUTE_BIT = 1;
	localparam logic [1:0] CTRL_RST = 2'h0;
	localparam logic [7:0] STD_RST = 8'h00;
	// Standard codes
	localparam logic [7:0] STD_AUTO = 8'h01;
	localparam logic [7:0] STD_KOREA = 8'h02;
	localparam logic [7:0] STD_BG_FM = 8'h03;
	localparam logic [7:0] STD_DK1 = 8'h04;
	localparam logic [7:0] STD_DK2 = 8'h05;
	localparam logic [7:0] STD_DK3 = 8'h07;
	localparam logic [7:0] STD_BG_NIC = 8'h08;
	localparam logic [7:0] STD_L_NIC = 8'h09;
	localparam logic [7:0] STD_I_NIC = 8'h0a;
	localparam logic [7:0] STD_DK_NIC = 8'h0b;
	localparam logic [7:0] STD_DK_NIC_HD = 8'h0c;
	localparam logic [7:0] STD_DK_NIC_HD2 = 8'h0d;
	localparam logic [7:0] STD_BTSC = 8'h20;
	localparam logic [7:0] STD_BTSC_SAP = 8'h21;
	localparam logic [7:0] STD_JAPAN = 8'h30;
	localparam logic [7:0] STD_RADIO = 8'h40;
	// Source select codes
	localparam logic [2:0] SRC_CODE_ANA = 3'h0;
	localparam logic [2:0] SRC_CODE_AB = 3'h1;
	localparam logic [2:0] SRC_CODE_A = 3'h3;
	localparam logic [2:0] SRC_CODE_B = 3'h4;
	// Timing and thresholds
	localparam int DK_NIC_DEV_KHZ = 384;
	localparam int ALT_STEPS = 4800;
	localparam int HYST_STEPS = 2400;
	localparam logic [7:0] ERR_HI = 8'hc0;
	localparam logic [7:0] ERR_LO = 8'h40;

	typedef enum logic [1:0] {DM_MONO, DM_STEREO, DM_BILING, DM_SAP} dematrix_t;
	typedef enum logic [1:0] {DE_50US, DE_75US, DE_J17} deemph_t;
	typedef enum logic [1:0] {SEC_CAR2, SEC_DIFF, SEC_SAP, SEC_NONE} sec_t;
	typedef enum logic [3:0] {S_MUTE, S_MONO, S_ST_L, S_ST_R, S_LANG_A,
		S_LANG_B, S_N_MONO, S_N_L, S_N_R, S_N_A, S_N_B, S_SAP} src_t;
	typedef struct packed {src_t left; src_t right;} chan_t;
	typedef struct packed {
		logic [13:0] tune1_khz;
		logic [13:0] tune2_khz;
		logic [9:0] max_dev_khz;
		deemph_t deemph;
		sec_t sec_kind;
		logic nicam;
	} demod_param_t;
	typedef struct packed {
		logic carrier1;
		logic carrier2;
		logic id_stereo;
		logic id_biling;
		logic pilot;
		logic sap;
		logic nicam_ok;
		logic [1:0] nicam_mode;
		logic [7:0] nicam_err;
	} demod_stat_t;
endpackage

// ==== design/snd_sel_ctrl.sv ====
// TV sound standard selection, auto detection, carrier mute and
// automatic sound selection. APB slave; demodulator on the same clock.
//
// Our own choices: the register addresses and the APB slave port.
`timescale 1ns/1ps
module snd_sel_ctrl #(
	parameter int ALT_STEPS = snd_sel_pkg::ALT_STEPS,
	parameter int HYST_STEPS = snd_sel_pkg::HYST_STEPS
) (
	input wire logic clk_sys_i, // 200 MHz system clock
	input wire logic rst_i, // Sync reset, active high
	input wire logic psel_i, // APB select
	input wire logic penable_i, // APB enable
	input wire logic pwrite_i, // APB direction
	input wire logic [7:0] paddr_i, // APB byte address
	input wire logic [31:0] pwdata_i, // APB write data
	output logic [31:0] prdata_o, // APB read data
	output logic pready_o, // APB ready
	output logic pslverr_o, // APB error, unmapped
	input wire logic step_i, // Processing step strobe
	input wire snd_sel_pkg::demod_stat_t stat_i, // Demodulator status
	input wire logic det_done_i, // Detection engine finished
	input wire logic [7:0] det_code_i, // Detected standard code
	output logic det_req_o, // Start detection pulse
	output snd_sel_pkg::demod_param_t param_o, // Demod parameters
	output logic [7:0] std_o, // Active standard code
	output snd_sel_pkg::dematrix_t dematrix_o, // Active dematrix
	output logic [1:0] mute_o, // Per-channel carrier mute
	output snd_sel_pkg::chan_t [3:0] src_o // Source channels 0,1,3,4
);
	////////////////////////////////////////////////////////////////////
	// Per-standard parameter table
	function automatic snd_sel_pkg::demod_param_t std_param(
		input logic [7:0] c);
		snd_sel_pkg::demod_param_t p;
		p = '{tune1_khz: 14'd5500, tune2_khz: 14'd5742,
			max_dev_khz: 10'd50, deemph: snd_sel_pkg::DE_50US,
			sec_kind: snd_sel_pkg::SEC_CAR2, nicam: 1'b0};
		case (c)
			snd_sel_pkg::STD_KOREA:
			begin
				p.tune1_khz = 14'd4500;
				p.tune2_khz = 14'd4724;
				p.deemph = snd_sel_pkg::DE_75US;
			end
			snd_sel_pkg::STD_DK1:
			begin
				p.tune1_khz = 14'd6500;
				p.tune2_khz = 14'd6258;
			end
			snd_sel_pkg::STD_DK2:
			begin
				p.tune1_khz = 14'd6500;
				p.tune2_khz = 14'd6742;
			end
			snd_sel_pkg::STD_DK3:
				p.tune1_khz = 14'd6500;
			snd_sel_pkg::STD_BG_NIC, snd_sel_pkg::STD_L_NIC,
			snd_sel_pkg::STD_I_NIC, snd_sel_pkg::STD_DK_NIC,
			snd_sel_pkg::STD_DK_NIC_HD, snd_sel_pkg::STD_DK_NIC_HD2:
			begin
				p.nicam = 1'b1;
				p.deemph = snd_sel_pkg::DE_J17;
				p.sec_kind = snd_sel_pkg::SEC_NONE;
				p.tune2_khz = 14'd5850;
				p.tune1_khz = (c == snd_sel_pkg::STD_BG_NIC) ?
					14'd5500 : 14'd6500;
				if (c == snd_sel_pkg::STD_I_NIC)
				begin
					p.tune1_khz = 14'd6000;
					p.tune2_khz = 14'd6552;
				end
				if (c != snd_sel_pkg::STD_BG_NIC &&
					c != snd_sel_pkg::STD_L_NIC &&
					c != snd_sel_pkg::STD_I_NIC)
					p.max_dev_khz = 10'(snd_sel_pkg::DK_NIC_DEV_KHZ); // [R20]
			end
			snd_sel_pkg::STD_BTSC, snd_sel_pkg::STD_BTSC_SAP,
			snd_sel_pkg::STD_JAPAN, snd_sel_pkg::STD_RADIO:
			begin
				p.tune1_khz = (c == snd_sel_pkg::STD_RADIO) ?
					14'd10700 : 14'd4500;
				p.tune2_khz = p.tune1_khz;
				p.deemph = snd_sel_pkg::DE_75US;
				p.sec_kind = (c == snd_sel_pkg::STD_BTSC_SAP) ?
					snd_sel_pkg::SEC_SAP : snd_sel_pkg::SEC_DIFF; // [R15]
			end
			default:
				p = p;
		endcase
		return p;
	endfunction

	// Group membership: 1 = B/G pair, 2 = D/K set, 0 = none
	function automatic logic [1:0] grp(input logic [7:0] c);
		case (c)
			snd_sel_pkg::STD_BG_FM, snd_sel_pkg::STD_BG_NIC:
				return 2'h1;
			snd_sel_pkg::STD_DK1, snd_sel_pkg::STD_DK2,
			snd_sel_pkg::STD_DK3, snd_sel_pkg::STD_DK_NIC:
				return 2'h2;
			default:
				return 2'h0;
		endcase
	endfunction

	function automatic logic [7:0] next_in_grp(input logic [7:0] c);
		case (c)
			snd_sel_pkg::STD_BG_FM: return snd_sel_pkg::STD_BG_NIC;
			snd_sel_pkg::STD_BG_NIC: return snd_sel_pkg::STD_BG_FM;
			snd_sel_pkg::STD_DK1: return snd_sel_pkg::STD_DK2;
			snd_sel_pkg::STD_DK2: return snd_sel_pkg::STD_DK3;
			snd_sel_pkg::STD_DK3: return snd_sel_pkg::STD_DK_NIC;
			default: return snd_sel_pkg::STD_DK1;
		endcase
	endfunction

	////////////////////////////////////////////////////////////////////
	logic [7:0] std_reg;
	logic [1:0] ctrl_reg;
	snd_sel_pkg::dematrix_t man_dm_reg;
	logic det_busy_reg;
	logic fallback_reg;
	logic [12:0] alt_cnt_reg;
	logic [12:0] hyst_cnt_reg;
	logic [1:0] mute_reg;
	snd_sel_pkg::dematrix_t dm_reg;
	snd_sel_pkg::dematrix_t dm_next;
	logic [31:0] rd_next;
	logic mapped;
	logic wr_en;
	logic std_wr;
	logic auto_on;
	logic is_nicam;
	logic ident;

	assign auto_on = ctrl_reg[snd_sel_pkg::CTRL_AUTO_BIT];
	assign is_nicam = param_o.nicam;
	assign wr_en = psel_i & penable_i & pwrite_i & mapped;
	assign std_wr = wr_en && paddr_i == snd_sel_pkg::OFS_STD;
	// Any stereo/bilingual sign, analog or digital, stops alternation
	assign ident = stat_i.id_stereo | stat_i.id_biling |
		(stat_i.nicam_ok && stat_i.nicam_mode != 2'h0);

	////////////////////////////////////////////////////////////////////
	// APB slave: read data sampled in setup, answer in first access
	always_comb
	begin
		mapped = 1'b1;
		rd_next = 32'h0;
		case (paddr_i)
			snd_sel_pkg::OFS_STD: rd_next = {24'h0, std_reg};
			snd_sel_pkg::OFS_CTRL: rd_next = {30'h0, ctrl_reg};
			snd_sel_pkg::OFS_DEMATRIX: rd_next = {30'h0, man_dm_reg};
			snd_sel_pkg::OFS_STATUS:
				rd_next = {15'h0, dm_reg, det_busy_reg, stat_i.sap,
					fallback_reg, stat_i.id_biling, stat_i.id_stereo,
					mute_reg, std_reg};
			snd_sel_pkg::OFS_PARAM:
				rd_next = {param_o.max_dev_khz, param_o.tune2_khz,
					param_o.deemph, param_o.sec_kind, 3'h0,
					param_o.nicam};
			default: mapped = 1'b0;
		endcase
	end

	assign pready_o = psel_i & penable_i;
	assign pslverr_o = psel_i & penable_i & ~mapped;

	always_ff @(posedge clk_sys_i)
	begin
		if (rst_i)
			prdata_o <= 32'h0;
		else if (psel_i & ~penable_i & ~pwrite_i)
			prdata_o <= rd_next;
	end

	////////////////////////////////////////////////////////////////////
	// Control and manual dematrix; code write re-arms carrier mute
	always_ff @(posedge clk_sys_i)
	begin
		if (rst_i)
			ctrl_reg <= snd_sel_pkg::CTRL_RST;
		else if (wr_en && paddr_i == snd_sel_pkg::OFS_CTRL)
			ctrl_reg <= pwdata_i[1:0];
		else if (std_wr)
			ctrl_reg[snd_sel_pkg::CTRL_MUTE_BIT] <= 1'b1; // [R3]
	end

	always_ff @(posedge clk_sys_i)
	begin
		if (rst_i)
			man_dm_reg <= snd_sel_pkg::DM_MONO;
		else if (wr_en && paddr_i == snd_sel_pkg::OFS_DEMATRIX)
			man_dm_reg <= snd_sel_pkg::dematrix_t'(pwdata_i[1:0]); // [R5]
	end

	////////////////////////////////////////////////////////////////////
	// Active standard: host write, detection result, group alternation
	always_ff @(posedge clk_sys_i)
	begin
		if (rst_i)
		begin
			std_reg <= snd_sel_pkg::STD_RST;
			det_busy_reg <= 1'b0;
			alt_cnt_reg <= 13'h0;
		end
		else if (std_wr)
		begin
			det_busy_reg <= pwdata_i[7:0] == snd_sel_pkg::STD_AUTO;
			if (pwdata_i[7:0] != snd_sel_pkg::STD_AUTO)
				std_reg <= pwdata_i[7:0]; // [R1]
			alt_cnt_reg <= 13'h0;
		end
		else if (det_busy_reg & det_done_i)
		begin
			std_reg <= det_code_i; // [R2]
			det_busy_reg <= 1'b0;
		end
		else if (step_i)
		begin
			// Stay on the standard where identification appeared
			if (!auto_on || grp(std_reg) == 2'h0 || ident)
				alt_cnt_reg <= 13'h0; // [R8]
			else if (alt_cnt_reg == 13'(ALT_STEPS - 1))
			begin
				alt_cnt_reg <= 13'h0;
				std_reg <= next_in_grp(std_reg); // [R7]
			end
			else
				alt_cnt_reg <= alt_cnt_reg + 13'h1;
		end
	end

	assign det_req_o = std_wr && pwdata_i[7:0] == snd_sel_pkg::STD_AUTO;

	// Parameters follow the code; deemphasis comes with them
	always_ff @(posedge clk_sys_i)
	begin
		if (rst_i)
			param_o <= std_param(snd_sel_pkg::STD_RST);
		else
			param_o <= std_param(std_reg); // [R1] [R4]
	end

	////////////////////////////////////////////////////////////////////
	// NICAM fallback: bad quickly, good only after a quiet hold time
	always_ff @(posedge clk_sys_i)
	begin
		if (rst_i)
		begin
			fallback_reg <= 1'b1;
			hyst_cnt_reg <= 13'h0;
		end
		else if (step_i)
		begin
			if (!stat_i.nicam_ok || stat_i.nicam_err >= snd_sel_pkg::ERR_HI)
			begin
				fallback_reg <= 1'b1; // [R9]
				hyst_cnt_reg <= 13'h0;
			end
			else if (fallback_reg && stat_i.nicam_err < snd_sel_pkg::ERR_LO)
			begin
				if (hyst_cnt_reg == 13'(HYST_STEPS - 1))
					fallback_reg <= 1'b0; // [R9]
				else
					hyst_cnt_reg <= hyst_cnt_reg + 13'h1;
			end
			else
				hyst_cnt_reg <= 13'h0;
		end
	end

	////////////////////////////////////////////////////////////////////
	// Automatic dematrix choice from identification
	always_comb
	begin
		dm_next = snd_sel_pkg::DM_MONO;
		if (!auto_on)
			dm_next = man_dm_reg; // [R5]
		else if (is_nicam)
		begin
			if (!fallback_reg && stat_i.nicam_mode == 2'h1)
				dm_next = snd_sel_pkg::DM_STEREO; // [R6]
			else if (!fallback_reg && stat_i.nicam_mode == 2'h2)
				dm_next = snd_sel_pkg::DM_BILING;
		end
		// Code 21 stays on pilot mono/stereo until the SAP carrier shows
		else if (std_reg == snd_sel_pkg::STD_BTSC_SAP && stat_i.sap)
			dm_next = snd_sel_pkg::DM_SAP; // [R17] [R21]
		else if (std_reg == snd_sel_pkg::STD_BTSC ||
			std_reg == snd_sel_pkg::STD_BTSC_SAP ||
			std_reg == snd_sel_pkg::STD_RADIO)
			dm_next = stat_i.pilot ? snd_sel_pkg::DM_STEREO :
				snd_sel_pkg::DM_MONO; // [R18] [R17]
		else if (stat_i.id_biling)
			dm_next = snd_sel_pkg::DM_BILING; // [R19]
		else if (stat_i.id_stereo)
			dm_next = snd_sel_pkg::DM_STEREO; // [R19]
	end

	// Dematrix and mute flags move on the same step as the status bits
	always_ff @(posedge clk_sys_i)
	begin
		if (rst_i)
		begin
			dm_reg <= snd_sel_pkg::DM_MONO;
			mute_reg <= 2'h0;
		end
		else if (step_i)
		begin
			dm_reg <= dm_next; // [R6] [R22]
			mute_reg <= {2{ctrl_reg[snd_sel_pkg::CTRL_MUTE_BIT]}} &
				~{stat_i.carrier2, stat_i.carrier1}; // [R3] [R22]
		end
	end

	assign dematrix_o = dm_reg;
	assign mute_o = mute_reg;
	assign std_o = std_reg;

	////////////////////////////////////////////////////////////////////
	// Source channel routing; index 0..3 holds codes 0, 1, 3, 4 [R10]
	always_ff @(posedge clk_sys_i)
	begin
		if (rst_i)
			src_o <= '{default: '{snd_sel_pkg::S_MUTE, snd_sel_pkg::S_MUTE}};
		else if (is_nicam)
		begin
			src_o[0] <= '{snd_sel_pkg::S_MONO, snd_sel_pkg::S_MONO}; // [R11]
			if (fallback_reg || dm_reg == snd_sel_pkg::DM_MONO)
				for (int i = 1; i < 4; i++)
					src_o[i] <= fallback_reg ?
						'{snd_sel_pkg::S_MONO, snd_sel_pkg::S_MONO} :
						'{snd_sel_pkg::S_N_MONO, snd_sel_pkg::S_N_MONO}; // [R16]
			else if (dm_reg == snd_sel_pkg::DM_BILING)
			begin
				src_o[1] <= '{snd_sel_pkg::S_N_A, snd_sel_pkg::S_N_B}; // [R12]
				src_o[2] <= '{snd_sel_pkg::S_N_A, snd_sel_pkg::S_N_A}; // [R13]
				src_o[3] <= '{snd_sel_pkg::S_N_B, snd_sel_pkg::S_N_B}; // [R14]
			end
			else
				for (int i = 1; i < 4; i++)
					src_o[i] <= '{snd_sel_pkg::S_N_L, snd_sel_pkg::S_N_R}; // [R16]
		end
		else
			case (dm_reg)
				snd_sel_pkg::DM_STEREO:
					for (int i = 0; i < 4; i++)
						src_o[i] <= '{snd_sel_pkg::S_ST_L, snd_sel_pkg::S_ST_R};
				snd_sel_pkg::DM_BILING:
				begin
					src_o[0] <= '{snd_sel_pkg::S_LANG_A, snd_sel_pkg::S_LANG_B};
					src_o[1] <= '{snd_sel_pkg::S_LANG_A,
						snd_sel_pkg::S_LANG_B}; // [R12]
					src_o[2] <= '{snd_sel_pkg::S_LANG_A,
						snd_sel_pkg::S_LANG_A}; // [R13]
					src_o[3] <= '{snd_sel_pkg::S_LANG_B,
						snd_sel_pkg::S_LANG_B}; // [R14]
				end
				snd_sel_pkg::DM_SAP:
				begin
					// Mono left, secondary programme right; A channel mono, B channel SAP
					src_o[0] <= '{snd_sel_pkg::S_MONO, snd_sel_pkg::S_SAP};
					src_o[1] <= '{snd_sel_pkg::S_MONO, snd_sel_pkg::S_SAP};
					src_o[2] <= '{snd_sel_pkg::S_MONO, snd_sel_pkg::S_MONO};
					src_o[3] <= '{snd_sel_pkg::S_SAP,
						snd_sel_pkg::S_SAP}; // [R21] [R17]
				end
				default:
					for (int i = 0; i < 4; i++)
						src_o[i] <= '{snd_sel_pkg::S_MONO, snd_sel_pkg::S_MONO};
			endcase
	end
endmodule

// ==== verif/snd_sel_properties.sv ====
// Checker of the sound select control block at its top-level ports.
// Assumes one clock, sync reset and zero-wait APB.
`timescale 1ns/1ps
module snd_sel_chk #(
	parameter int ALT_STEPS = snd_sel_pkg::ALT_STEPS,
	parameter int HYST_STEPS = snd_sel_pkg::HYST_STEPS
) (
	input wire logic clk_sys_i, // Clock
	input wire logic rst_i, // Sync reset
	input wire logic psel_i, // Select
	input wire logic penable_i, // Enable
	input wire logic pwrite_i, // Direction
	input wire logic [7:0] paddr_i, // Address
	input wire logic [31:0] pwdata_i, // Write data
	input wire logic pready_o, // Ready
	input wire logic pslverr_o, // Error
	input wire logic step_i, // Step strobe
	input wire snd_sel_pkg::demod_stat_t stat_i, // Demod status
	input wire logic det_done_i, // Detect done
	input wire logic det_req_o, // Detect request
	input wire snd_sel_pkg::demod_param_t param_o, // Parameters
	input wire logic [7:0] std_o, // Standard
	input wire snd_sel_pkg::dematrix_t dematrix_o, // Dematrix
	input wire logic [1:0] mute_o, // Mute
	input wire snd_sel_pkg::chan_t [3:0] src_o // Sources
);
	logic wr, wr_std, men, auto_sel;
	logic [1:0] car;
	////////////////////////////////////////
	// Decode shared by several checks
	assign wr = psel_i && penable_i && pwrite_i;
	assign wr_std = wr && paddr_i == snd_sel_pkg::OFS_STD;
	assign car = {stat_i.carrier2, stat_i.carrier1};
	// Shadow of control bits; a standard write re-arms mute only
	always_ff @(posedge clk_sys_i)
	begin
		if (rst_i)
			{men, auto_sel} <= 2'b00;
		else if (wr_std)
			men <= 1'b1;
		else if (wr && paddr_i == snd_sel_pkg::OFS_CTRL)
			{men, auto_sel} <= pwdata_i[1:0];
	end
	default clocking @(posedge clk_sys_i); endclocking
	default disable iff (rst_i);
	a_ready_access: assert property (pready_o == (psel_i && penable_i))
		else $error("ready not tied to access");
	a_err_unmapped: assert property (psel_i && penable_i &&
		paddr_i[1:0] == 2'h0 |-> pslverr_o == (paddr_i > 8'h10))
		else $error("error flag wrong for address");
	a_detect_pulse: assert property (
		det_req_o == (wr_std && pwdata_i[7:0] == snd_sel_pkg::STD_AUTO))
		else $error("detect request mismatch");
	a_std_write: assert property (
		wr_std && pwdata_i[7:0] != snd_sel_pkg::STD_AUTO
		|=> std_o == $past(pwdata_i[7:0]))
		else $error("standard code not taken");
	a_std_hold: assert property (
		!wr_std && !det_done_i && !step_i |=> $stable(std_o))
		else $error("standard changed without cause");
	a_param_dev: assert property (
		(std_o == snd_sel_pkg::STD_DK_NIC) [*2]
		|-> param_o.max_dev_khz == 10'h180)
		else $error("deviation limit wrong");
	a_mute_step: assert property (
		step_i |=> mute_o == ($past(men) ? ~$past(car) : 2'b00))
		else $error("carrier mute wrong");
	a_mute_hold: assert property (!step_i |=> $stable(mute_o))
		else $error("mute moved off step");
	a_dm_hold: assert property (!step_i |=> $stable(dematrix_o))
		else $error("dematrix moved off step");
	a_ab_biling: assert property (
		auto_sel && std_o == snd_sel_pkg::STD_BG_FM ##1
		auto_sel && dematrix_o == snd_sel_pkg::DM_BILING &&
		std_o == snd_sel_pkg::STD_BG_FM
		|=> src_o[1] == {snd_sel_pkg::S_LANG_A, snd_sel_pkg::S_LANG_B})
		else $error("bilingual routing wrong");
	c_detect: cover property (det_req_o);
	c_mute: cover property (mute_o == 2'b10);
	c_unmapped: cover property (pslverr_o);
endmodule
bind snd_sel_ctrl snd_sel_chk #(.ALT_STEPS(ALT_STEPS),
	.HYST_STEPS(HYST_STEPS)) u_chk (.clk_sys_i(clk_sys_i), .rst_i(rst_i),
	.psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i),
	.paddr_i(paddr_i), .pwdata_i(pwdata_i), .pready_o(pready_o),
	.pslverr_o(pslverr_o), .step_i(step_i), .stat_i(stat_i),
	.det_done_i(det_done_i), .det_req_o(det_req_o), .param_o(param_o),
	.std_o(std_o), .dematrix_o(dematrix_o), .mute_o(mute_o),
	.src_o(src_o));

// ==== verif/demod_model.sv ====
// Detection engine and step source facing the control block.
// Assumes the bench gates steps and picks the code to report.
`timescale 1ns/1ps
module demod_model (
	input wire logic clk_sys_i, // Clock
	input wire logic rst_i, // Sync reset
	input wire logic run_i, // Let steps run
	input wire logic slow_i, // Long search
	input wire logic det_req_i, // Detect request
	input wire logic [7:0] code_i, // Code to report
	output logic step_o, // Step pulse
	output logic det_done_o, // Detect done
	output logic [7:0] det_code_o // Detected code
);
	logic [1:0] ph_reg;
	logic [4:0] wait_reg;
	logic [7:0] code_reg;
	////////////////////////////////////////
	// One step in four cycles while running
	always_ff @(posedge clk_sys_i)
	begin
		ph_reg <= rst_i ? 2'h0 : ph_reg + 2'h1;
		step_o <= !rst_i && run_i && ph_reg == 2'h3;
	end
	// Short or long search, then one done pulse
	always_ff @(posedge clk_sys_i)
	begin
		det_done_o <= !rst_i && wait_reg == 5'h1;
		if (rst_i)
			wait_reg <= 5'h0;
		else if (det_req_i)
			wait_reg <= slow_i ? 5'h10 : 5'h2;
		else if (wait_reg != 5'h0)
			wait_reg <= wait_reg - 5'h1;
		if (det_req_i)
			code_reg <= code_i;
	end
	// Code only valid with done; inverse hides stale values
	assign det_code_o = det_done_o ? code_reg : ~code_reg;
endmodule

// ==== verif/testbench.sv ====
// Self-checking bench for the sound select control block.
// Assumes the demod model supplies steps and detection answers.
`timescale 1ns/1ps
`define CHK(n, e, s) begin tests_run++; if ((s) !== (e)) begin failures++; \
	$display("ERROR %s exp %0h got %0h", n, e, s); end end
module testbench;
	localparam logic [7:0] std_a = snd_sel_pkg::OFS_STD;
	localparam logic [7:0] ctl_a = snd_sel_pkg::OFS_CTRL;
	localparam logic [7:0] dm_a = snd_sel_pkg::OFS_DEMATRIX;
	localparam logic [7:0] st_a = snd_sel_pkg::OFS_STATUS;
	logic clk_sys_i = 1'b0, rst_i = 1'b1, psel = 1'b0, pen = 1'b0;
	logic pwr = 1'b0, run = 1'b0, slow = 1'b1;
	logic [7:0] paddr = 8'h0, code = 8'h4, dcode, std;
	logic [31:0] pwdata = 32'h0, d, prdata;
	logic step, done, req, pready, perr;
	logic [1:0] mute;
	logic [64:0] q[$];
	logic [64:0] e;
	snd_sel_pkg::demod_stat_t stat = '0;
	snd_sel_pkg::demod_param_t param;
	snd_sel_pkg::dematrix_t dm;
	snd_sel_pkg::chan_t [3:0] src;
	int failures = 0, tests_run = 0;
	////////////////////////////////////////
	snd_sel_ctrl #(.ALT_STEPS(4), .HYST_STEPS(3)) DUT (.clk_sys_i(clk_sys_i),
		.rst_i(rst_i), .psel_i(psel), .penable_i(pen), .pwrite_i(pwr),
		.paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
		.pready_o(pready), .pslverr_o(perr), .step_i(step), .stat_i(stat),
		.det_done_i(done), .det_code_i(dcode), .det_req_o(req),
		.param_o(param), .std_o(std), .dematrix_o(dm), .mute_o(mute),
		.src_o(src));
	demod_model model (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .run_i(run),
		.slow_i(slow), .det_req_i(req), .code_i(code), .step_o(step),
		.det_done_o(done), .det_code_o(dcode));
	always #2.5 clk_sys_i = ~clk_sys_i;
	// One transfer, held until ready; idle cycle after it
	task apb(input logic w, input logic [7:0] a, input logic [31:0] v);
		psel <= 1'b1;
		pen <= 1'b0;
		pwr <= w;
		paddr <= a;
		pwdata <= v;
		@(posedge clk_sys_i);
		pen <= 1'b1;
		@(posedge clk_sys_i);
		while (!pready)
			@(posedge clk_sys_i);
		psel <= 1'b0;
		pen <= 1'b0;
		@(posedge clk_sys_i);
	endtask
	// Note the expected answer, then read
	task rd(input logic [7:0] a, input logic [31:0] x, m, input logic er);
		q.push_back({er, m, x});
		apb(1'b0, a, 32'h0);
	endtask
	// Let n steps pass, then let routing settle
	task steps(input int n);
		run <= 1'b1;
		repeat (n)
		begin
			@(posedge clk_sys_i);
			while (!step)
				@(posedge clk_sys_i);
		end
		run <= 1'b0;
		repeat (2)
			@(posedge clk_sys_i);
	endtask
	task cs(input int i, input snd_sel_pkg::src_t l, r);
		`CHK("src", {l, r}, src[i])
	endtask
	task test_done;
		$display("checks %0d failures %0d", tests_run, failures);
		if (failures == 0 && tests_run > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	// Completed reads are matched with the oldest note
	always @(posedge clk_sys_i)
	begin
		if (psel && pen && pready && !pwr)
		begin
			e = q.pop_front();
			`CHK("rdata", e[31:0] & e[63:32], prdata & e[63:32])
			`CHK("slverr", e[64], perr)
		end
	end
	// Cuts a hang short well past the expected run length
	initial
	begin
		#100000;
		failures++;
		test_done;
	end
	initial
	begin
		void'($urandom(32'h446657e4));
		repeat (2)
			@(posedge clk_sys_i);
		rst_i <= 1'b0;
		@(posedge clk_sys_i);
		rd(std_a, 32'h0, 32'hff, 1'b0);
		rd(ctl_a, 32'h0, 32'h3, 1'b0);
		rd(st_a, 32'h1000, 32'h1d3ff, 1'b0);
		rd(8'h20, 32'h0, 32'hffffffff, 1'b1);
		apb(1'b1, std_a, 32'h0b);
		apb(1'b1, 8'h20, 32'hff);
		rd(std_a, 32'h0b, 32'hff, 1'b0);
		rd(ctl_a, 32'h2, 32'h3, 1'b0);
		rd(8'h10, 32'h60000000, 32'hffc00000, 1'b0);
		$display("test registers done");
		stat.carrier1 <= 1'b1;
		apb(1'b1, std_a, 32'h04);
		steps(1);
		rd(st_a, 32'h204, 32'h3ff, 1'b0);
		apb(1'b1, ctl_a, 32'h0);
		d = $urandom;
		apb(1'b1, dm_a, d);
		steps(1);
		rd(st_a, {d[1:0], 15'h0}, 32'h18300, 1'b0);
		rd(dm_a, d & 32'h3, 32'h3, 1'b0);
		$display("test mute done");
		stat.carrier2 <= 1'b1;
		stat.id_biling <= 1'b1;
		apb(1'b1, std_a, 32'h03);
		apb(1'b1, ctl_a, 32'h3);
		steps(2);
		rd(st_a, 32'h10003, 32'h180ff, 1'b0);
		cs(1, snd_sel_pkg::S_LANG_A, snd_sel_pkg::S_LANG_B);
		cs(2, snd_sel_pkg::S_LANG_A, snd_sel_pkg::S_LANG_A);
		cs(3, snd_sel_pkg::S_LANG_B, snd_sel_pkg::S_LANG_B);
		stat.id_biling <= 1'b0;
		stat.id_stereo <= 1'b1;
		steps(8);
		rd(st_a, 32'h8003, 32'h180ff, 1'b0);
		cs(2, snd_sel_pkg::S_ST_L, snd_sel_pkg::S_ST_R);
		stat.id_stereo <= 1'b0;
		steps(2);
		rd(std_a, 32'h03, 32'hff, 1'b0);
		steps(3);
		rd(std_a, 32'h08, 32'hff, 1'b0);
		$display("test identification done");
		stat.nicam_ok <= 1'b1;
		stat.nicam_mode <= 2'h1;
		steps(1);
		rd(st_a, 32'h1000, 32'h1000, 1'b0);
		steps(3);
		rd(st_a, 32'h0, 32'h1000, 1'b0);
		cs(0, snd_sel_pkg::S_MONO, snd_sel_pkg::S_MONO);
		cs(1, snd_sel_pkg::S_N_L, snd_sel_pkg::S_N_R);
		stat.nicam_err <= 8'hc0;
		steps(1);
		rd(st_a, 32'h1000, 32'h1000, 1'b0);
		cs(3, snd_sel_pkg::S_MONO, snd_sel_pkg::S_MONO);
		$display("test fallback done");
		for (int i = 0; i < 2; i++)
		begin
			slow <= i[0];
			code <= $urandom_range(1) ? 8'h04 : 8'h0b;
			apb(1'b1, std_a, 32'h01);
			rd(st_a, 32'h4008, 32'h4000, 1'b0);
			for (int j = 0; j < 40 && !done; j++)
				@(posedge clk_sys_i);
			@(posedge clk_sys_i);
			rd(st_a, {24'h0, code}, 32'h40ff, 1'b0);
			apb(1'b1, std_a, 32'h08);
		end
		$display("test detection done");
		stat.sap <= 1'b1;
		apb(1'b1, std_a, 32'h21);
		steps(2);
		rd(st_a, 32'h2000, 32'h2000, 1'b0);
		cs(1, snd_sel_pkg::S_MONO, snd_sel_pkg::S_SAP);
		cs(3, snd_sel_pkg::S_SAP, snd_sel_pkg::S_SAP);
		stat.sap <= 1'b0;
		stat.pilot <= 1'b1;
		steps(2);
		cs(1, snd_sel_pkg::S_ST_L, snd_sel_pkg::S_ST_R);
		apb(1'b1, std_a, 32'h40);
		steps(2);
		cs(1, snd_sel_pkg::S_ST_L, snd_sel_pkg::S_ST_R);
		$display("test sap done");
		test_done;
	end
endmodule
